// file: ubi_pkg.sv
// constants, register map and field layout of the baud rate and interrupt core
// assumes one 125 MHz clock that serves both as bus clock and oscillator input
//
// Notes on behaviour
// (RL1) after its last access the host returns the serial clock pin low
// (RL2) low reset pulse over 40 ns returns all registers and outputs to defaults
// (RL3) fifo mode: tx irq pin high while free spaces below trigger, else low; code also holds it high when spaces equal trigger
// (RL4) non-fifo auto direction mode: irq high while holding byte waits, low when empty
// (RL5) rx irq high with no data in non-fifo; fifo mode high below trigger; code also high when level equals trigger
// (RL6) non-fifo receiver drives irq low while a received byte waits
// (RL7) reset leaves the block in non-fifo mode; software enables fifo mode
// (RL8) one oscillator clock feeds both rate generators; bus access needs no oscillator; code clocks the bus from the oscillator mclk_i
// (RL9) each channel has own generator and prescaler; modem control bit 7 picks /1 or /4
// (RL10) divisor from 1 to 65536 minus 1/16 in 1/16 steps gives sampling clock
// (RL11) sampling clock times transmitter bit shifting and receiver data sampling
// (RL12) reset divisor is one: low byte 01, high byte 00, fraction 00
// (RL13) low and high bytes give integer part, fraction register gives fraction
// (RL14) low four fraction bits select N sixteenths, 0000 to 1111
// (RL15) prescaler set gives one quarter of the bypassed data rate
// (RL16) 8x mode jitters one sixteenth when fraction is odd and nonzero
// (RL17) software programs the divisor at initialisation; reset value is unusable
// (RL18) fraction bits 5:4 pick sampling: 00 16x, 01 8x, 10 4x
// (RL19) 4x mode jitters one eighth when fraction odd, nonzero, not multiple of 4
// (RL20) divisor or prescaler writes restart the generator count from the new value
package ubi_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // register map, byte offsets inside one channel
    // ****************************************
    localparam logic [4:0] OFS_DIV_LO = 5'h00;
    localparam logic [4:0] OFS_DIV_HI = 5'h04;
    localparam logic [4:0] OFS_DIV_FRAC = 5'h08;
    localparam logic [4:0] OFS_MODEM_CTRL = 5'h0C;
    localparam logic [4:0] OFS_FIFO_CTRL = 5'h10;
    localparam logic [4:0] OFS_AUX_CTRL = 5'h14;
    localparam logic [4:0] OFS_TRIG = 5'h18;
    localparam logic [4:0] OFS_STATUS = 5'h1C;
    localparam int CH_SEL_BIT = 5;
    localparam int MAP_TOP_BIT = 6;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_DIV_LO = 8'h01;
    localparam logic [7:0] RST_DIV_HI = 8'h00;
    localparam logic [7:0] RST_DIV_FRAC = 8'h00;
    localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
    localparam logic [7:0] RST_FIFO_CTRL = 8'h00;
    localparam logic [7:0] RST_AUX_CTRL = 8'h00;
    localparam logic [6:0] RST_TX_TRIG = 7'h20;
    localparam logic [6:0] RST_RX_TRIG = 7'h20;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FIFO_EN_BIT = 0;
    localparam int PRESC_BIT = 7;
    localparam int AUTO_DIR_BIT = 0;
    localparam int FRAC_MSB = 3;
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 5;
    localparam int TX_TRIG_LSB = 0;
    localparam int RX_TRIG_LSB = 8;
    localparam int ST_TX_LSB = 0;
    localparam int ST_RX_LSB = 8;
    localparam int ST_IRQ_BIT = 16;
    localparam int ST_PRESC_BIT = 17;
    localparam int LVL_W = 7;

    // ****************************************
    // sampling modes and bus encodings
    // ****************************************
    typedef enum logic [1:0] {
        UBI_SAMP_16X = 2'b00,
        UBI_SAMP_8X = 2'b01,
        UBI_SAMP_4X = 2'b10
    } ubi_samp_t;
    localparam logic [4:0] SAMPLES_16X = 5'h10;
    localparam logic [4:0] SAMPLES_8X = 5'h08;
    localparam logic [4:0] SAMPLES_4X = 5'h04;
    localparam logic [20:0] SIXTEENTH_ONE = 21'h00_0010;
    localparam logic [1:0] PRESC_LAST = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// file: ubi_prescale.sv
// prescaler of one channel: passes every oscillator cycle or every fourth
// assumes restart_i pulses for one cycle when the divide ratio is rewritten
`timescale 1ns/1ns
module ubi_prescale (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic div4_i,
    output logic tick_o
);

    logic [1:0] cnt_r;

    // ****************************************
    // divide by one or four
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 2'h0;
        end else if (restart_i) begin
            cnt_r <= 2'h0; // RL20
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
        end else if (restart_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= div4_i ? (cnt_r == ubi_pkg::PRESC_LAST) : 1'b1; // RL9 RL15
        end
    end

endmodule // ubi_prescale

// file: ubi_rate_gen.sv
// fractional rate generator of one channel: sampling tick and bit tick
// assumes in_tick_i comes from the prescaler and restart_i from a divisor write
`timescale 1ns/1ns
module ubi_rate_gen (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic in_tick_i,
    input wire logic [15:0] div_int_i,
    input wire logic [3:0] div_frac_i,
    input wire logic [1:0] mode_i,
    output logic samp_tick_o,
    output logic bit_tick_o
);

    logic [20:0] acc_r;
    logic [4:0] samp_cnt_r;
    logic [20:0] target;
    logic [20:0] acc_add;
    logic [4:0] samp_per_bit;

    // ****************************************
    // divisor in sixteenths, integer zero counts as 65536
    // ****************************************
    always_comb begin
        target = {1'b0, div_int_i, div_frac_i}; // RL13 RL14
        if (div_int_i == 16'h0000) begin
            target = {1'b1, 16'h0000, div_frac_i};
        end
        acc_add = acc_r + ubi_pkg::SIXTEENTH_ONE;
        case (mode_i) // RL18
            ubi_pkg::UBI_SAMP_8X: samp_per_bit = ubi_pkg::SAMPLES_8X;
            ubi_pkg::UBI_SAMP_4X: samp_per_bit = ubi_pkg::SAMPLES_4X;
            default: samp_per_bit = ubi_pkg::SAMPLES_16X;
        endcase
    end

    // ****************************************
    // accumulator: a tick each time a whole divisor has passed
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= 21'h00_0000;
            samp_tick_o <= 1'b0;
        end else if (restart_i) begin
            acc_r <= 21'h00_0000; // RL20
            samp_tick_o <= 1'b0;
        end else if (in_tick_i && acc_add >= target) begin
            acc_r <= acc_add - target; // RL10 RL16 RL19
            samp_tick_o <= 1'b1;
        end else if (in_tick_i) begin
            acc_r <= acc_add;
            samp_tick_o <= 1'b0;
        end else begin
            samp_tick_o <= 1'b0;
        end
    end

    // ****************************************
    // one bit time per 16, 8 or 4 sampling ticks
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            samp_cnt_r <= 5'h00;
            bit_tick_o <= 1'b0;
        end else if (restart_i) begin
            samp_cnt_r <= 5'h00;
            bit_tick_o <= 1'b0;
        end else if (samp_tick_o && samp_cnt_r + 5'h01 >= samp_per_bit) begin
            samp_cnt_r <= 5'h00; // RL11
            bit_tick_o <= 1'b1;
        end else if (samp_tick_o) begin
            samp_cnt_r <= samp_cnt_r + 5'h01;
            bit_tick_o <= 1'b0;
        end else begin
            bit_tick_o <= 1'b0;
        end
    end

endmodule // ubi_rate_gen

// file: ubi_core.sv
// two-channel baud rate and interrupt core with an AHB-Lite register slave
// assumes mclk_i is both bus clock and oscillator, and channel status inputs are synchronous
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module ubi_core #(
    parameter int NCH = 2
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic [NCH*7-1:0] tx_spaces_i,
    input wire logic [NCH*7-1:0] rx_level_i,
    input wire logic [NCH-1:0] thr_full_i,
    input wire logic [NCH-1:0] rhr_valid_i,
    output logic [NCH-1:0] irq_n_o,
    output logic [NCH-1:0] samp_tick_o,
    output logic [NCH-1:0] bit_tick_o,
    output logic [NCH*2-1:0] samp_mode_o
);

    // ****************************************
    // register storage, one entry per channel
    // ****************************************
    logic [7:0] div_lo_r [NCH];
    logic [7:0] div_hi_r [NCH];
    logic [7:0] div_frac_r [NCH];
    logic [7:0] modem_ctrl_r [NCH];
    logic [7:0] fifo_ctrl_r [NCH];
    logic [7:0] aux_ctrl_r [NCH];
    logic [6:0] tx_trig_r [NCH];
    logic [6:0] rx_trig_r [NCH];
    logic [NCH-1:0] restart_r;

    logic wr_pend_r;
    logic [4:0] wr_ofs_r;
    logic wr_ch_r;

    logic addr_phase;
    logic in_map;
    logic [4:0] a_ofs;
    logic a_ch;
    logic [NCH-1:0] presc_tick;
    logic [NCH-1:0] samp_tick;
    logic [NCH-1:0] bit_tick;
    logic [NCH-1:0] irq_n_nxt;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [6:0] lvl(input logic [NCH*7-1:0] v, input int ch);
        lvl = v[ch*7 +: 7];
    endfunction

    function automatic logic is_ch_reg(input logic [4:0] ofs);
        is_ch_reg = (ofs == ubi_pkg::OFS_DIV_LO) || (ofs == ubi_pkg::OFS_DIV_HI) ||
            (ofs == ubi_pkg::OFS_DIV_FRAC) || (ofs == ubi_pkg::OFS_MODEM_CTRL);
    endfunction

    // ****************************************
    // bus decode
    // ****************************************
    always_comb begin
        addr_phase = hsel_i && hready_i && (htrans_i == ubi_pkg::HTRANS_NONSEQ);
        in_map = (haddr_i[31:ubi_pkg::MAP_TOP_BIT] == '0) &&
            (int'(haddr_i[ubi_pkg::CH_SEL_BIT]) < NCH);
        a_ofs = haddr_i[4:0];
        a_ch = haddr_i[ubi_pkg::CH_SEL_BIT];
    end

    // bus answers in zero wait states, always OKAY
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b0;
            hresp_o <= ubi_pkg::HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1; // RL8
            hresp_o <= ubi_pkg::HRESP_OKAY;
        end
    end

    // address phase of a write is kept for its data phase
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 5'h00;
            wr_ch_r <= 1'b0;
        end else begin
            wr_pend_r <= addr_phase && hwrite_i && in_map;
            wr_ofs_r <= a_ofs;
            wr_ch_r <= a_ch;
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < NCH; c++) begin
                div_lo_r[c] <= ubi_pkg::RST_DIV_LO; // RL2 RL12
                div_hi_r[c] <= ubi_pkg::RST_DIV_HI;
                div_frac_r[c] <= ubi_pkg::RST_DIV_FRAC;
                modem_ctrl_r[c] <= ubi_pkg::RST_MODEM_CTRL;
                fifo_ctrl_r[c] <= ubi_pkg::RST_FIFO_CTRL; // RL7
                aux_ctrl_r[c] <= ubi_pkg::RST_AUX_CTRL;
                tx_trig_r[c] <= ubi_pkg::RST_TX_TRIG;
                rx_trig_r[c] <= ubi_pkg::RST_RX_TRIG;
            end
        end else if (wr_pend_r) begin
            case (wr_ofs_r)
                ubi_pkg::OFS_DIV_LO: begin
                    div_lo_r[wr_ch_r] <= hwdata_i[7:0]; // RL13
                end
                ubi_pkg::OFS_DIV_HI: begin
                    div_hi_r[wr_ch_r] <= hwdata_i[7:0]; // RL13
                end
                ubi_pkg::OFS_DIV_FRAC: begin
                    div_frac_r[wr_ch_r] <= {2'b00, hwdata_i[5:0]}; // RL14 RL18
                end
                ubi_pkg::OFS_MODEM_CTRL: begin
                    modem_ctrl_r[wr_ch_r] <= hwdata_i[7:0]; // RL9
                end
                ubi_pkg::OFS_FIFO_CTRL: begin
                    fifo_ctrl_r[wr_ch_r] <= hwdata_i[7:0];
                end
                ubi_pkg::OFS_AUX_CTRL: begin
                    aux_ctrl_r[wr_ch_r] <= hwdata_i[7:0];
                end
                ubi_pkg::OFS_TRIG: begin
                    tx_trig_r[wr_ch_r] <= hwdata_i[ubi_pkg::TX_TRIG_LSB +: 7];
                    rx_trig_r[wr_ch_r] <= hwdata_i[ubi_pkg::RX_TRIG_LSB +: 7];
                end
                default: begin
                end
            endcase
        end
    end

    // a write to the divisor or prescaler restarts that channel's generator
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            restart_r <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                restart_r[c] <= wr_pend_r && (int'(wr_ch_r) == c) && is_ch_reg(wr_ofs_r); // RL20
            end
        end
    end

    // ****************************************
    // read data, sampled in the address phase
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_i && in_map) begin
            case (a_ofs)
                ubi_pkg::OFS_DIV_LO: hrdata_o <= {24'h00_0000, div_lo_r[a_ch]};
                ubi_pkg::OFS_DIV_HI: hrdata_o <= {24'h00_0000, div_hi_r[a_ch]};
                ubi_pkg::OFS_DIV_FRAC: hrdata_o <= {24'h00_0000, div_frac_r[a_ch]};
                ubi_pkg::OFS_MODEM_CTRL: hrdata_o <= {24'h00_0000, modem_ctrl_r[a_ch]};
                ubi_pkg::OFS_FIFO_CTRL: hrdata_o <= {24'h00_0000, fifo_ctrl_r[a_ch]};
                ubi_pkg::OFS_AUX_CTRL: hrdata_o <= {24'h00_0000, aux_ctrl_r[a_ch]};
                ubi_pkg::OFS_TRIG: begin
                    hrdata_o <= {17'h0_0000, rx_trig_r[a_ch], 1'b0, tx_trig_r[a_ch]};
                end
                ubi_pkg::OFS_STATUS: begin
                    hrdata_o <= {14'h0000, modem_ctrl_r[a_ch][ubi_pkg::PRESC_BIT],
                        irq_n_o[a_ch], 1'b0, lvl(rx_level_i, int'(a_ch)), 1'b0,
                        lvl(tx_spaces_i, int'(a_ch))};
                end
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end else begin
            hrdata_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // per-channel prescaler and rate generator
    // ****************************************
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        ubi_prescale u_presc (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .restart_i(restart_r[g]),
            .div4_i(modem_ctrl_r[g][ubi_pkg::PRESC_BIT]), // RL9 RL15
            .tick_o(presc_tick[g])
        );

        ubi_rate_gen u_rate (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .restart_i(restart_r[g]),
            .in_tick_i(presc_tick[g]),
            .div_int_i({div_hi_r[g], div_lo_r[g]}), // RL10 RL13
            .div_frac_i(div_frac_r[g][ubi_pkg::FRAC_MSB:0]),
            .mode_i(div_frac_r[g][ubi_pkg::MODE_MSB:ubi_pkg::MODE_LSB]),
            .samp_tick_o(samp_tick[g]),
            .bit_tick_o(bit_tick[g])
        );
    end

    // ****************************************
    // interrupt pin: high means nothing pending
    // ****************************************
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            logic tx_high;
            logic rx_high;
            tx_high = 1'b1;
            rx_high = 1'b1;
            if (fifo_ctrl_r[c][ubi_pkg::FIFO_EN_BIT]) begin
                tx_high = (lvl(tx_spaces_i, c) <= tx_trig_r[c]); // RL3
                rx_high = (lvl(rx_level_i, c) <= rx_trig_r[c]); // RL5
            end else begin
                tx_high = aux_ctrl_r[c][ubi_pkg::AUTO_DIR_BIT] ? thr_full_i[c] : 1'b1; // RL4
                rx_high = !rhr_valid_i[c]; // RL5 RL6
            end
            irq_n_nxt[c] = tx_high && rx_high;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_n_o <= '1; // RL2
        end else begin
            irq_n_o <= irq_n_nxt;
        end
    end

    // ****************************************
    // timing outputs to transmitter and receiver
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            samp_tick_o <= '0;
            bit_tick_o <= '0;
            samp_mode_o <= '0;
        end else begin
            samp_tick_o <= samp_tick; // RL11
            bit_tick_o <= bit_tick;
            for (int c = 0; c < NCH; c++) begin
                samp_mode_o[c*2 +: 2] <= div_frac_r[c][ubi_pkg::MODE_MSB:ubi_pkg::MODE_LSB];
            end
        end
    end

endmodule // ubi_core

// file: ubi_core_props.sv
// checker: bus answer, channel 0 irq pin, prescaled tick gap
// assumes hready_i is tied to hreadyout_o
`timescale 1ns/1ns
module ubi_core_props #(
    parameter int NCH = 2
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o,
    input wire logic [NCH*7-1:0] tx_spaces_i,
    input wire logic [NCH*7-1:0] rx_level_i,
    input wire logic [NCH-1:0] thr_full_i,
    input wire logic [NCH-1:0] rhr_valid_i,
    input wire logic [NCH-1:0] irq_n_o,
    input wire logic [NCH-1:0] samp_tick_o
);
    // ****
    // channel 0 setup from bus writes
    // ****
    logic wv_r, rd_r, fifo_r, aux_r, pre_r, take, tx_hi, rx_hi;
    logic [5:0] wa_r;
    logic [6:0] ttx_r, trx_r;
    assign take = hsel_i && hready_i && htrans_i == ubi_pkg::HTRANS_NONSEQ;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wv_r <= 1'b0;
            rd_r <= 1'b0;
            wa_r <= 6'h00;
        end else if (hready_i) begin
            wv_r <= take && hwrite_i && haddr_i < 32'h0000_0040;
            rd_r <= take && !hwrite_i;
            wa_r <= haddr_i[5:0];
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {pre_r, fifo_r, aux_r} <= 3'h0;
            ttx_r <= ubi_pkg::RST_TX_TRIG;
            trx_r <= ubi_pkg::RST_RX_TRIG;
        end else if (wv_r) begin
            case (wa_r)
                6'h0C: pre_r <= hwdata_i[7];
                6'h10: fifo_r <= hwdata_i[0];
                6'h14: aux_r <= hwdata_i[0];
                6'h18: {trx_r, ttx_r} <= {hwdata_i[14:8], hwdata_i[6:0]};
                default: ;
            endcase
        end
    end
    assign tx_hi = fifo_r ? tx_spaces_i[6:0] <= ttx_r : !aux_r || thr_full_i[0];
    assign rx_hi = fifo_r ? rx_level_i[6:0] <= trx_r : !rhr_valid_i[0];
    // ****
    // properties
    // ****
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_gap;
        (!samp_tick_o[0] || !pre_r) [*3];
    endsequence
    sequence s_wr_fifo;
        take && hwrite_i ##1 wv_r && wa_r == 6'h10;
    endsequence
    chk_irq_fifo_tx: assert property (
        $past(rst_n_i, 2) && $past(fifo_r && rx_hi) |-> irq_n_o[0] == $past(tx_hi))
        else $error("irq fifo tx");
    chk_irq_dir_tx: assert property (
        $past(rst_n_i, 2) && $past(!fifo_r && aux_r && rx_hi) |-> irq_n_o[0] == $past(tx_hi))
        else $error("irq dir tx");
    chk_irq_fifo_rx: assert property (
        $past(rst_n_i, 2) && $past(fifo_r && tx_hi) |-> irq_n_o[0] == $past(rx_hi))
        else $error("irq fifo rx");
    chk_irq_rx_byte: assert property (
        $past(rst_n_i, 2) && $past(!fifo_r && rhr_valid_i[0]) |-> !irq_n_o[0])
        else $error("irq rx byte");
    chk_irq_no_data: assert property (
        $past(rst_n_i, 2) && $past(!fifo_r && !aux_r && !rhr_valid_i[0]) |-> irq_n_o[0])
        else $error("irq no data");
    chk_reset_idle: assert property (
        $rose(rst_n_i) |-> irq_n_o == '1 && hrdata_o == 32'h0000_0000)
        else $error("reset values");
    chk_rdata_idle: assert property (
        !rd_r |-> hrdata_o == 32'h0000_0000 && !hresp_o)
        else $error("idle read data");
    chk_presc_gap: assert property (
        samp_tick_o[0] && pre_r && $past(pre_r, 3) |=> s_gap)
        else $error("prescaled tick gap");
    cov_wr_fifo: cover property (s_wr_fifo);
endmodule // ubi_core_props
bind ubi_core ubi_core_props #(.NCH(NCH)) u_ubi_core_props (.*);

// file: ubi_chan_model.sv
// channel model: fifo and holding status to the core, tick counters
// assumes set_i changes just after a clock edge
`timescale 1ns/1ns
module ubi_chan_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic [15:0] set_i,
    input wire logic [1:0] samp_tick_i,
    input wire logic [1:0] bit_tick_i,
    output logic [13:0] tx_spaces_o,
    output logic [13:0] rx_level_o,
    output logic [1:0] thr_full_o,
    output logic [1:0] rhr_valid_o,
    output logic [15:0] samp0_o,
    output logic [15:0] samp1_o,
    output logic [15:0] bit0_o
);
    // status: set_i is {thr, rhr, spaces, level}, same for both channels
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {thr_full_o, rhr_valid_o, tx_spaces_o, rx_level_o} <= 32'h0000_0000;
        end else begin
            thr_full_o <= {2{set_i[15]}};
            rhr_valid_o <= {2{set_i[14]}};
            tx_spaces_o <= {2{set_i[13:7]}};
            rx_level_o <= {2{set_i[6:0]}};
        end
    end
    // ticks consumed by the far side
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i || clr_i) begin
            {samp0_o, samp1_o, bit0_o} <= 48'h0000_0000_0000;
        end else begin
            samp0_o <= samp0_o + 16'(samp_tick_i[0]);
            samp1_o <= samp1_o + 16'(samp_tick_i[1]);
            bit0_o <= bit0_o + 16'(bit_tick_i[0]);
        end
    end
endmodule // ubi_chan_model

// file: testbench.sv
// bench of the core: registers, irq pins and tick rates
// assumes the checker binds itself to the core
`timescale 1ns/1ns
module testbench;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, clr = 1'b0, dp_rd = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [15:0] set = 16'h0000;
    wire logic hready, hresp;
    wire logic [31:0] hrdata;
    wire logic [1:0] irq_n, st, bt, transmit_holding_reg, receive_holding_reg;
    wire logic [3:0] mode;
    wire logic [13:0] sp, lv;
    wire logic [15:0] s0, s1, b0;
    int n_mismatch = 0, tests_run = 0, cyc = 0, seed = 31225;
    logic [31:0] q[$];
    logic [31:0] rst_val [7] = '{32'h0000_0001, 0, 0, 0, 0, 0, 32'h0000_2020};
    // {irq, fifo, aux, thr, rhr, spaces, level}
    logic [18:0] vec [8] = '{{5'h01, 14'h0000}, {5'h10, 14'h0000}, {5'h16, 14'h0000},
        {5'h04, 14'h0000}, {5'h18, 7'h10, 7'h00}, {5'h08, 7'h11, 7'h00},
        {5'h08, 7'h00, 7'h21}, {5'h19, 7'h00, 7'h20}};
    ubi_core u_ubi_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .tx_spaces_i(sp), .rx_level_i(lv), .thr_full_i(transmit_holding_reg),
        .rhr_valid_i(receive_holding_reg), .irq_n_o(irq_n), .samp_tick_o(st), .bit_tick_o(bt),
        .samp_mode_o(mode));
    ubi_chan_model u_ubi_chan_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clr_i(clr),
        .set_i(set), .samp_tick_i(st), .bit_tick_i(bt), .tx_spaces_o(sp),
        .rx_level_o(lv), .thr_full_o(transmit_holding_reg), .rhr_valid_o(receive_holding_reg), .samp0_o(s0),
        .samp1_o(s1), .bit0_o(b0));
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    // ****
    // compares and bus tasks
    // ****
    task automatic cmp(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_rng(input string nm, input logic [31:0] e, g);
        tests_run++;
        if ($isunknown(g) || g + 2 < e || g > e + 2) begin
            n_mismatch++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk_i);
        hsel <= 1'b1;
        htrans <= ubi_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        dp_rd <= !w;
        do @(posedge mclk_i); while (hready !== 1'b1);
        dp_rd <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, d);
        ahb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [31:0] a, e);
        q.push_back(e);
        ahb(a, 1'b0, 32'h0000_0000);
    endtask
    always @(posedge mclk_i) begin
        if (dp_rd === 1'b1 && hready === 1'b1) begin
            cmp("hrdata", q.pop_front(), hrdata);
        end
    end
    task automatic rate(input logic [15:0] di, input logic [3:0] fr, input logic [1:0] m,
        input logic pre);
        int e;
        wr(32'h0000_0000, 32'(di[7:0]));
        wr(32'h0000_0004, 32'(di[15:8]));
        wr(32'h0000_0008, 32'({m, fr}));
        wr(32'h0000_000C, 32'({pre, 7'h00}));
        repeat (100) @(posedge mclk_i);
        clr <= 1'b1;
        @(posedge mclk_i);
        clr <= 1'b0;
        repeat (3200) @(posedge mclk_i);
        #1;
        e = 3200 * 16 / ((pre ? 4 : 1) * (16 * di + fr));
        cmp_rng("samp0", e, s0);
        cmp_rng("bit0", e >> (4 - m), b0);
        cmp_rng("samp1", 3200, s1);
        cmp("mode0", 32'(m), 32'(mode[1:0]));
        rd(32'h0000_0008, 32'({m, fr}));
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        // longer than the minimum pulse
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        for (int c = 0; c < 2; c++) begin
            foreach (rst_val[i]) rd(32'(c * 32 + i * 4), rst_val[i]);
        end
        wr(32'h0000_0040, 32'hFFFF_FFFF);
        rd(32'h0000_0040, 32'h0000_0000);
        wr(32'h0000_0018, 32'h0000_2010);
        foreach (vec[i]) begin
            wr(32'h0000_0010, 32'(vec[i][17]));
            wr(32'h0000_0014, 32'(vec[i][16]));
            @(posedge mclk_i);
            set <= vec[i][15:0];
            repeat (4) @(posedge mclk_i);
            #1;
            cmp("irq_n0", 32'(vec[i][18]), 32'(irq_n[0]));
            cmp("irq_n1", 32'(!vec[i][14]), 32'(irq_n[1]));
        end
        for (int m = 0; m < 4; m++) begin
            rate(16'(2 + {$random(seed)} % 8), 4'($random(seed)), 2'(m % 3), m == 3);
        end
        finish_test();
    end
endmodule // testbench
